// *** logic/sacp_top.sv ***
`default_nettype none
// Summary of operation
// - a falling convert_start_n while chip select is low starts a conversion
// - convert-start edges are ignored until the running conversion has finished
// - busy is low for the whole conversion and high again at its end
// - high_byte_select picks the high or low part of the result on byte lanes
// - conversion takes about 6 us so 100 ksps is kept with 2 us acquisition
// - with chip select and read low the data outputs stay enabled
// - with read high the data outputs stay in high impedance
// - joined read and start low begins conversion while the old result shows
// - at conversion end the new result shows and busy rises
// - each joined low pulse starts a conversion and returns the previous result
// - while sleep is low no conversion can start
// - after sleep release a 3 ms wake-up precedes reference_ready rising
// - nap low powers down all but reference; leaving nap takes 620 ns
// - comparator powers after sleep rises, and on the differential variant only while nap is also high
// - bipolar codes are two's complement, or offset binary on the differential variant
// - one lsb weighs full scale over 4096
module sacp_top #(
	parameter int unsigned WAKE_CYCLES = sacp_pkg::WAKE_CYCLES, // sleep wake count
	parameter bit          DIFF_VARIANT = 1'b0,                 // offset binary and nap
	parameter bit          BYTE_WIDE    = 1'b0                  // two byte read format
) (
	input  wire logic        clk,              // 20 MHz system clock
	input  wire logic        rst,              // async reset, high
	input  wire logic        cs_n,             // chip select, low
	input  wire logic        rd_n,             // read, low
	input  wire logic        convert_start_n,  // conversion start, falling edge
	input  wire logic        high_byte_select, // byte lane select
	input  wire logic        sleep_n,          // sleep, low
	input  wire logic        nap_n,            // nap, low
	input  wire logic        bipolar,          // bipolar coding select
	input  wire logic [11:0] sample_code,      // raw comparator result, offset binary
	input  wire logic        sample_valid,     // raw result present
	output logic             sample_ready,     // raw result taken
	output logic             busy_n,           // low while converting
	output logic             reference_ready,  // high once awake
	output logic             comparator_on,    // comparator power
	output logic [11:0]      data_out,         // data pins, output value
	output logic [11:0]      data_oe           // data pins, output enable
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	// three flops per pin; two agreeing stages filter one-cycle glitches
	// costs about four cycles of latency on every control pin except bipolar, which is used unsynchronised
	localparam int NP = 6;
	logic [NP-1:0] s1, s2, s3;
	logic [NP-1:0] pin_in;
	sacp_pkg::sacp_ctl_t ctl;
	assign pin_in = {cs_n, rd_n, convert_start_n, high_byte_select, sleep_n, nap_n};

	// first stage read only by the second
	// reset to the idle levels of the pins so no false edge follows reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1 <= '1;
			s2 <= '1;
			s3 <= '1;
		end else begin
			s1 <= pin_in;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// a level counts once stages two and three agree
	logic [NP-1:0] stable;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stable <= '1;
		end else begin
			for (int i = 0; i < NP; i++) begin
				if (s2[i] == s3[i]) begin
					stable[i] <= s3[i];
				end
			end
		end
	end
	assign ctl = sacp_pkg::sacp_ctl_t'(stable);

	// ****************************************
	// power state
	// ****************************************
	logic [sacp_pkg::CNT_W-1:0] wake_cnt;
	logic [7:0]                 nap_cnt;
	logic                       nap_ok;
	logic                       awake;
	assign awake = reference_ready && nap_ok;

	// sleep wake-up timer; restarts on every sleep
	// limitation: wake time is a fixed count, not a measure of the reference
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wake_cnt        <= '0;
			reference_ready <= 1'b0;
		end else if (!ctl.sleep_n) begin
			wake_cnt        <= '0;
			reference_ready <= 1'b0;
		end else if (!reference_ready) begin
			if (wake_cnt == sacp_pkg::CNT_W'(WAKE_CYCLES - 1)) begin
				reference_ready <= 1'b1;
			end
			wake_cnt <= wake_cnt + 1'b1;
		end
	end

	// nap recovery only exists on the differential variant
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nap_cnt <= '0;
			nap_ok  <= 1'b0;
		end else if (DIFF_VARIANT && !ctl.nap_n) begin
			nap_cnt <= '0;
			nap_ok  <= 1'b0;
		end else if (!nap_ok) begin
			if (nap_cnt >= 8'(sacp_pkg::NAP_CYCLES - 1) || !DIFF_VARIANT) begin
				nap_ok <= 1'b1;
			end
			nap_cnt <= nap_cnt + 1'b1;
		end
	end

	// comparator follows sleep release, and nap release too on the differential variant
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			comparator_on <= 1'b0;
		end else begin
			comparator_on <= ctl.sleep_n && (!DIFF_VARIANT || ctl.nap_n);
		end
	end

	// ****************************************
	// two-entry buffer for raw results
	// ****************************************
	sacp_pkg::sacp_word_t buf_mem [2];
	logic       wr_ptr, rd_ptr;
	logic [1:0] buf_cnt;
	logic [1:0] next_buf_cnt;
	logic       buf_out_valid, buf_out_ready;
	sacp_pkg::sacp_word_t buf_out;
	assign buf_out_valid = (buf_cnt != 2'd0);
	assign buf_out       = buf_mem[rd_ptr];

	// count after this cycle's push and pop; ready is registered from it
	always_comb begin
		next_buf_cnt = buf_cnt;
		if (sample_valid && sample_ready) begin
			next_buf_cnt = next_buf_cnt + 2'd1;
		end
		if (buf_out_valid && buf_out_ready) begin
			next_buf_cnt = next_buf_cnt - 2'd1;
		end
	end

	// stalls at the comparator side when full so no word is lost
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr  <= 1'b0;
			rd_ptr  <= 1'b0;
			buf_cnt <= 2'd0;
			sample_ready <= 1'b1;
			buf_mem[0] <= '0;
			buf_mem[1] <= '0;
		end else begin
			if (sample_valid && sample_ready) begin
				buf_mem[wr_ptr] <= sacp_pkg::sacp_word_t'(sample_code);
				wr_ptr          <= !wr_ptr;
			end
			if (buf_out_valid && buf_out_ready) begin
				rd_ptr <= !rd_ptr;
			end
			buf_cnt      <= next_buf_cnt;
			sample_ready <= (next_buf_cnt != 2'd2);
		end
	end

	// ****************************************
	// conversion sequencer
	// ****************************************
	typedef enum logic [1:0] {
		SACP_IDLE = 2'b01,
		SACP_CONV = 2'b10
	} sacp_state_t;
	sacp_state_t state;
	logic [7:0]  conv_cnt;
	logic        conv_d;
	logic        start_edge;
	logic        done;
	logic [11:0] result;

	// start edge gated by select and power; sleep and nap gate at once,
	// since the ready flags only drop one cycle later
	assign start_edge = conv_d && !ctl.conv_n && !ctl.cs_n && awake && ctl.sleep_n
		&& (ctl.nap_n || !DIFF_VARIANT);
	assign done = (state == SACP_CONV) && (conv_cnt == 8'(sacp_pkg::CONV_CYCLES - 1));
	assign buf_out_ready = done;

	// conv_d starts high like the synchronised pin; a pin held low at reset still falls, and awake blocks that start
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conv_d <= 1'b1;
		end else begin
			conv_d <= ctl.conv_n;
		end
	end

	// the last cycle waits for a buffered word, so a slow feed stretches busy
	// trade-off: a missing raw word holds busy low instead of showing stale data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state    <= SACP_IDLE;
			conv_cnt <= '0;
		end else begin
			case (state)
				SACP_IDLE: begin
					conv_cnt <= '0;
					if (start_edge) begin
						state <= SACP_CONV;
					end
				end
				SACP_CONV: begin
					if (done && buf_out_valid) begin
						state <= SACP_IDLE;
					end else if (!done) begin
						conv_cnt <= conv_cnt + 1'b1;
					end
				end
				default: state <= SACP_IDLE;
			endcase
		end
	end

	// busy and result update together, old result shown meanwhile
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_n <= 1'b1;
			result <= sacp_pkg::RESULT_RESET;
		end else if (state == SACP_IDLE && start_edge) begin
			busy_n <= 1'b0;
		end else if (done && buf_out_valid) begin
			busy_n <= 1'b1;
			// lsb = full scale / 4096; two's complement flips the msb
			if (bipolar && !DIFF_VARIANT) begin
				result <= buf_out.code ^ sacp_pkg::BIPOLAR_FLIP;
			end else begin
				result <= buf_out.code;
			end
		end
	end

	// ****************************************
	// lane selection
	// ****************************************
	// narrow format: the upper nibble rides the low lane, zero padded
	function automatic logic [11:0] lane_pick(input logic [11:0] word, input logic high);
		logic [11:0] lane;
		lane = high ? {8'h00, word[11:8]} : {4'h0, word[7:0]};
		return lane;
	endfunction

	// ****************************************
	// data pins
	// ****************************************
	// the enable follows the synchronised strobes, so it lags the pins
	// by a few cycles; hosts must allow for that before sampling
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_out <= '0;
			data_oe  <= '0;
		end else begin
			data_oe <= (!ctl.cs_n && !ctl.rd_n) ? '1 : '0;
			if (BYTE_WIDE) begin
				data_out <= lane_pick(result, ctl.hbe);
			end else begin
				data_out <= result;
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence s_start;
		start_edge && state == SACP_IDLE;
	endsequence
	sequence s_busy_run;
		!busy_n [*8];
	endsequence
	sequence s_conv_end;
		done && buf_out_valid;
	endsequence
	// nap checks gate on the variant parameter

	a_start_busy_low: assert property (@(posedge clk) disable iff (rst)
		s_start |=> s_busy_run)
		else $error("busy did not fall after start");
	a_no_restart: assert property (@(posedge clk) disable iff (rst)
		state == SACP_CONV && !done |=> state == SACP_CONV)
		else $error("conversion cut short");
	a_busy_in_conv: assert property (@(posedge clk) disable iff (rst)
		state == SACP_CONV |-> !busy_n)
		else $error("busy high during conversion");
	a_conv_length: assert property (@(posedge clk) disable iff (rst)
		s_start |=> (state == SACP_CONV) [*8] ##[113:120] busy_n)
		else $error("conversion length wrong");
	a_sleep_blocks: assert property (@(posedge clk) disable iff (rst)
		!ctl.sleep_n && state == SACP_IDLE |=> state == SACP_IDLE)
		else $error("conversion started in sleep");
	a_ready_drop: assert property (@(posedge clk) disable iff (rst)
		!ctl.sleep_n |=> !reference_ready)
		else $error("ready high in sleep");
	a_ready_rise: assert property (@(posedge clk) disable iff (rst)
		$rose(reference_ready) |-> wake_cnt == sacp_pkg::CNT_W'(WAKE_CYCLES))
		else $error("ready rose early");
	a_data_drive: assert property (@(posedge clk) disable iff (rst)
		ctl.rd_n |=> data_oe == '0)
		else $error("data driven without read");
	a_result_hold: assert property (@(posedge clk) disable iff (rst)
		!busy_n && !$rose(busy_n) |=> $stable(result) || busy_n)
		else $error("result changed during conversion");
	a_oe_on_read: assert property (@(posedge clk) disable iff (rst)
		!ctl.cs_n && !ctl.rd_n |=> data_oe == '1)
		else $error("data not driven during read");
	a_busy_rise: assert property (@(posedge clk) disable iff (rst)
		s_conv_end |=> busy_n)
		else $error("busy did not rise at conversion end");
	a_busy_stays: assert property (@(posedge clk) disable iff (rst)
		state == SACP_CONV && !done |=> !busy_n)
		else $error("busy rose inside conversion");
	a_comp_sleep: assert property (@(posedge clk) disable iff (rst)
		!ctl.sleep_n |=> !comparator_on)
		else $error("comparator powered in sleep");
	a_nap_blocks: assert property (@(posedge clk) disable iff (rst)
		DIFF_VARIANT && !ctl.nap_n && state == SACP_IDLE |=> state == SACP_IDLE)
		else $error("conversion started in nap");
endmodule
`default_nettype wire

// *** logic/sacp_pkg.sv ***
`default_nettype none
// ****************************************
// shared constants and carriers
// ****************************************
package sacp_pkg;
	localparam int RES_BITS        = 12;
	localparam int CLK_HZ          = 20_000_000;
	localparam int CONV_TIME_NS    = 6000;   // typical conversion time
	localparam int ACQ_TIME_NS     = 2000;   // longest acquisition time
	localparam int WAKE_TIME_US    = 3000;   // sleep release to ready
	localparam int NAP_WAKE_NS     = 620;    // nap release to active
	localparam int CONV_CYCLES     = CONV_TIME_NS / 50;           // longest: round down
	localparam int NAP_CYCLES      = (NAP_WAKE_NS + 49) / 50;     // least: round up
	localparam int WAKE_CYCLES     = WAKE_TIME_US * (CLK_HZ / 1_000_000);
	localparam int CNT_W           = 17;
	localparam logic [11:0] RESULT_RESET = 12'h000;
	localparam logic [11:0] BIPOLAR_FLIP = 12'h800;  // msb flip from offset binary to two's complement

	// one conversion result code
	typedef struct packed {
		logic [11:0] code;
	} sacp_word_t;

	// control pins after synchronisation
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic conv_n;
		logic hbe;
		logic sleep_n;
		logic nap_n;
	} sacp_ctl_t;
endpackage
`default_nettype wire

// *** bench/sacp_sample_src.sv ***
`default_nettype none
// ****************************************
// raw comparator result source
// ****************************************
module sacp_sample_src (
	input  wire logic        clk,   // system clock
	input  wire logic        rst,   // async reset, high
	input  wire logic        stall, // hold back results
	input  wire logic        ready, // result taken
	output logic [11:0]      code,  // raw result
	output logic             valid  // result present
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [11:0] cur;
	// step the code per take so every conversion gets a distinct word
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cur <= 12'h123;
		else if (valid && ready)
			cur <= cur + 12'h111;
	end
	// idle lines show the inverse so a stale word is never mistaken
	assign valid = !stall;
	assign code  = valid ? cur : ~cur;
endmodule
`default_nettype wire

// *** bench/sampling_adc_control_port_tb.sv ***
`default_nettype none
module sampling_adc_control_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst = 1, cs_n = 1, rd_n = 1, cv_n = 1, hbs = 0;
	logic        sleep_n = 1, nap_n = 1, bipolar = 0, stall = 0;
	logic [11:0] code, dout, doe;
	logic        sv, sr, busy_n, rr, con;
	int          failures = 0, check_count = 0, n_conv = 0, len;
	// ****************************************
	// clock, design and source
	// ****************************************
	initial forever #25 clk = ~clk;
	sacp_top #(.WAKE_CYCLES(20)) sacp_top_inst (.clk(clk), .rst(rst), .cs_n(cs_n),
		.rd_n(rd_n), .convert_start_n(cv_n), .high_byte_select(hbs), .sleep_n(sleep_n),
		.nap_n(nap_n), .bipolar(bipolar), .sample_code(code), .sample_valid(sv),
		.sample_ready(sr), .busy_n(busy_n), .reference_ready(rr), .comparator_on(con),
		.data_out(dout), .data_oe(doe));
	sacp_sample_src sacp_sample_src_inst (.clk(clk), .rst(rst), .stall(stall),
		.ready(sr), .code(code), .valid(sv));
	// ****************************************
	// helpers
	// ****************************************
	task automatic finish_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// narrow start pulse; dbl fires a second pulse mid-conversion
	task automatic conv(input bit dbl);
		len = 0;
		@(posedge clk);
		cv_n <= 1'b0;
		for (int k = 0; k < 300; k++) begin
			@(posedge clk);
			if (k == 8 || k == 48)
				cv_n <= 1'b1;
			if (dbl && k == 40)
				cv_n <= 1'b0;
			if (busy_n === 1'b0)
				len++;
			if (len > 0 && busy_n === 1'b1)
				break;
		end
	endtask
	// a full conversion whose busy length and result are judged
	task automatic good_conv(input bit dbl);
		conv(dbl);
		chk(12'(len >= 118 && len <= 122), 12'h001);
		tick(3);
		chk(doe, 12'hFFF);
		chk(dout, (12'h123 + 12'(n_conv) * 12'h111) ^ (bipolar ? 12'h800 : 12'h000));
		n_conv++;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic s_reset(input logic [11:0] rest);
		chk(12'({busy_n, rr, doe[0]}), rest);
		for (int k = 0; k < 60 && rr !== 1'b1; k++)
			tick(1);
		chk(12'(rr), 12'h001);
		chk(12'(con), 12'h001);
	endtask
	task automatic s_modes();
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		good_conv(0);
		bipolar <= 1'b1;
		good_conv(0);
		bipolar <= 1'b0;
		stall <= 1'b1;
		good_conv(1);
		stall <= 1'b0;
		tick(30);
		chk(12'(busy_n), 12'h001);
	endtask
	task automatic s_refused();
		cs_n <= 1'b1;
		conv(0);
		chk(12'(len), 12'h000);
		cs_n <= 1'b0;
		rd_n <= 1'b1;
		tick(8);
		chk(doe, 12'h000);
		rd_n <= 1'b0;
		sleep_n <= 1'b0;
		tick(8);
		chk(12'(con), 12'h000);
		conv(0);
		chk(12'(len), 12'h000);
		sleep_n <= 1'b1;
		s_reset(12'h005);
		good_conv(0);
	endtask
	// joined read and start: slow-memory hold, then a narrow ROM pulse
	task automatic s_joined();
		logic [11:0] prev;
		prev = 12'h123 + 12'(n_conv - 1) * 12'h111;
		rd_n <= 1'b1;
		tick(8);
		rd_n <= 1'b0;
		cv_n <= 1'b0;
		tick(40);
		chk(12'(busy_n), 12'h000);
		chk(dout, prev);
		for (int k = 0; k < 200 && busy_n !== 1'b1; k++)
			tick(1);
		tick(2);
		chk(dout, prev + 12'h111);
		rd_n <= 1'b1;
		cv_n <= 1'b1;
		tick(8);
		rd_n <= 1'b0;
		cv_n <= 1'b0;
		tick(8);
		chk(dout, prev + 12'h111);
		rd_n <= 1'b1;
		cv_n <= 1'b1;
		for (int k = 0; k < 200 && busy_n !== 1'b1; k++)
			tick(1);
		tick(2);
		chk(dout, prev + 12'h222);
	endtask
	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		tick(5);
		rst <= 1'b0;
		tick(2);
		s_reset(12'h004);
		s_modes();
		s_refused();
		s_joined();
		finish_test();
	end
	initial begin
		#(50 * 8000);
		failures++;
		finish_test();
	end
endmodule
`default_nettype wire
